// *** core/mmpd_pkg.sv ***
// Constants and carrier types for the memory map and page decode block
package mmpd_pkg;

	// ---------------------------------------------------------------
	// Register offsets inside the configuration space
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_PAGE   = 8'he0;
	localparam logic [7:0] OFF_MAP    = 8'he2;
	localparam logic [7:0] OFF_OMC_AB = 8'h20;
	localparam logic [7:0] OFF_OMC_BC = 8'h21;
	localparam logic [7:0] OFF_IMC_A  = 8'h18;
	localparam logic [7:0] OFF_IMC_B  = 8'h19;
	localparam logic [7:0] OFF_IMC_C  = 8'h1a;

	// ---------------------------------------------------------------
	// Space map fields and reset values
	// ---------------------------------------------------------------
	localparam int MAP_RAM_CODE  = 0;
	localparam int MAP_SEC_CODE  = 1;
	localparam int MAP_PRI_CODE  = 2;
	localparam int MAP_SEC_DATA  = 3;
	localparam int MAP_PRI_DATA  = 4;
	localparam int MAP_PIO       = 7;
	localparam logic [7:0] MAP_USED_MASK = 8'h9f;
	localparam logic [7:0] MAP_RESET     = 8'h0c;
	localparam logic [7:0] PAGE_RESET    = 8'h00;

	// ---------------------------------------------------------------
	// Array input bus and product terms
	// ---------------------------------------------------------------
	localparam int BUS_W     = 73;
	localparam int PRI_N     = 8;
	localparam int SEC_N     = 4;
	localparam int FL_TERMS  = 3;
	localparam int RAM_TERMS = 2;
	localparam int SEC_T0    = PRI_N * FL_TERMS;
	localparam int RAM_T0    = SEC_T0 + SEC_N * FL_TERMS;
	localparam int CFG_T     = RAM_T0 + RAM_TERMS;
	localparam int JTAG_T    = CFG_T + 1;
	localparam int PER_T0    = JTAG_T + 1;
	localparam int DEC_TERMS = PER_T0 + 2;
	localparam int GEN_TERMS = 137;
	localparam int OMC_N     = 16;
	localparam int IMC_N     = 24;
	localparam int ECS_N     = 3;

	// ---------------------------------------------------------------
	// Standby timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STBY_NS       = 70;
	localparam logic [3:0] STBY_CYC = 4'(STBY_NS / CLK_PERIOD_NS);

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       byte_high;
		logic       addr_latch;
		logic       fetch;
		logic       read;
		logic       write;
	} mmpd_ctrl_s;

	typedef struct packed {
		logic [7:0] primary;
		logic [3:0] secondary;
		logic       ram;
		logic       cfg;
		logic       jtag;
		logic [1:0] periph;
	} mmpd_sel_s;

endpackage

// *** core/mmpd_core.sv ***
// Space mapping, page register, decode array and general logic array
//
// Function
// - Map bits 0 to 4 each open one strobe path; bit 7 enables peripheral mode.
// - Eight-bit page register, writable and readable at config offset E0h.
// - Page bits feed the decode array for sector and SRAM selects.
// - Page bits also feed the general logic array.
// - Page flip-flops load from and drive data bits 0 to 7.
// - With turbo off, standby_o flags standby after about 70 ns of stable inputs; the arrays stay awake.
// - Five block bits keep chosen control strobes out of the arrays.
// - Arrays share one 73-signal input bus.
// - In 20-bit mode array address inputs are bits 19 to 4.
// - Eight primary sector selects, three product terms each.
// - Four secondary sector selects, three product terms each.
// - One SRAM select of two terms and one config space select.
// - One test port select and two peripheral selects for peripheral mode.
// - General array drives three external chip selects without macrocells.
// - General array has 137 product terms for 19 outputs.
// - Output macrocells sit on the data bus, loadable and readable directly; input macrocells are readable only.
// - Map starts from a configured value and may be rewritten any time.
// - SRAM, config and peripheral beat flash; secondary beats primary.
`timescale 1ns/1ps
module mmpd_core
	import mmpd_pkg::*;
#(
	parameter logic [7:0]                   MAP_INIT = MAP_RESET,
	parameter logic [DEC_TERMS*BUS_W-1:0]   DEC_CARE = '0,
	parameter logic [DEC_TERMS*BUS_W-1:0]   DEC_VAL  = '0,
	parameter logic [GEN_TERMS*BUS_W-1:0]   GEN_CARE = '0,
	parameter logic [GEN_TERMS*BUS_W-1:0]   GEN_VAL  = '0,
	parameter logic [OMC_N*GEN_TERMS-1:0]   OMC_SEL  = '0,
	parameter logic [ECS_N*GEN_TERMS-1:0]   ECS_SEL  = '0
)
(
	// Clock and reset
	input  wire logic               mclk_i,
	input  wire logic               reset_n_i,
	// Microcontroller bus
	input  wire logic [19:0]        addr_i,
	input  wire mmpd_ctrl_s         ctrl_i,
	input  wire logic [7:0]         data_i,
	output logic [7:0]              data_o,
	output logic                    data_oe_o,
	input  wire logic               mode_20bit_i,
	// Power management controls
	input  wire logic               turbo_i,
	input  wire logic [4:0]         ctrl_block_i,
	input  wire logic               power_down_input_i,
	// Other array inputs
	input  wire logic [IMC_N-1:0]   input_macrocell_i,
	input  wire logic [2:0]         port_d_i,
	input  wire logic               sec_ready_i,
	// Selects and array outputs
	output mmpd_sel_s               sel_o,
	output logic [7:0]              page_bits_o,
	output logic                    peripheral_io_mode_enable_o,
	output logic [ECS_N-1:0]        external_chip_selects_o,
	output logic [OMC_N-1:0]        output_macrocell_o,
	output logic                    standby_o
);

	// ---------------------------------------------------------------
	// Input bus
	// ---------------------------------------------------------------
	logic [7:0]           page_r;
	logic [7:0]           map_r;
	logic [OMC_N-1:0]     omc_r;
	logic [4:0]           ctrl_eff;
	logic [15:0]          arr_addr;
	logic [BUS_W-1:0]     in_bus;
	logic [DEC_TERMS-1:0] dterm;
	logic [GEN_TERMS-1:0] gterm;
	logic [OMC_N-1:0]     omc_d;
	logic [ECS_N-1:0]     ecs_d;

	// Blocked strobes read as inactive inside the arrays only
	assign ctrl_eff = ctrl_i & ~ctrl_block_i;
	assign arr_addr = mode_20bit_i ? addr_i[19:4] : addr_i[15:0];
	assign in_bus = {sec_ready_i, omc_r, page_r, port_d_i,
		input_macrocell_i, power_down_input_i, ~reset_n_i,
		ctrl_eff[2:0], arr_addr};

	// ---------------------------------------------------------------
	// Product terms
	// ---------------------------------------------------------------
	// A term with no care bits is unused and never matches
	genvar gi;
	generate
		for (gi = 0; gi < DEC_TERMS; gi++)
		begin : g_dec
			assign dterm[gi] = (|DEC_CARE[gi*BUS_W +: BUS_W]) &&
				((in_bus & DEC_CARE[gi*BUS_W +: BUS_W]) ==
				(DEC_VAL[gi*BUS_W +: BUS_W] &
				DEC_CARE[gi*BUS_W +: BUS_W]));
		end
		for (gi = 0; gi < GEN_TERMS; gi++)
		begin : g_gen
			assign gterm[gi] = (|GEN_CARE[gi*BUS_W +: BUS_W]) &&
				((in_bus & GEN_CARE[gi*BUS_W +: BUS_W]) ==
				(GEN_VAL[gi*BUS_W +: BUS_W] &
				GEN_CARE[gi*BUS_W +: BUS_W]));
		end
		for (gi = 0; gi < OMC_N; gi++)
		begin : g_omc
			assign omc_d[gi] = |(gterm & OMC_SEL[gi*GEN_TERMS +: GEN_TERMS]);
		end
		for (gi = 0; gi < ECS_N; gi++)
		begin : g_ecs
			assign ecs_d[gi] = |(gterm & ECS_SEL[gi*GEN_TERMS +: GEN_TERMS]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Decode array
	// ---------------------------------------------------------------
	mmpd_sel_s sel_nxt;
	mmpd_sel_s sel_r;
	logic      cfg_hit;
	logic      pri_ok;
	logic      sec_ok;
	logic      ram_ok;

	always_comb
	begin
		sel_nxt = '0;
		for (int s = 0; s < PRI_N; s++)
			sel_nxt.primary[s] = |dterm[s*FL_TERMS +: FL_TERMS];
		for (int s = 0; s < SEC_N; s++)
			sel_nxt.secondary[s] =
				|dterm[SEC_T0 + s*FL_TERMS +: FL_TERMS];
		sel_nxt.ram  = |dterm[RAM_T0 +: RAM_TERMS];
		sel_nxt.cfg  = dterm[CFG_T];
		sel_nxt.jtag = dterm[JTAG_T];
		sel_nxt.periph = dterm[PER_T0 +: 2] & {2{map_r[MAP_PIO]}};
		// Strobe gating through the space map
		pri_ok = (ctrl_i.read && map_r[MAP_PRI_DATA]) ||
			(ctrl_i.fetch && map_r[MAP_PRI_CODE]);
		sec_ok = (ctrl_i.read && map_r[MAP_SEC_DATA]) ||
			(ctrl_i.fetch && map_r[MAP_SEC_CODE]);
		ram_ok = ctrl_i.read || ctrl_i.write ||
			(ctrl_i.fetch && map_r[MAP_RAM_CODE]);
		// Priority is taken on the ungated spaces so an overlap never
		// lets flash answer inside an SRAM window
		if (sel_nxt.ram || sel_nxt.cfg || (|sel_nxt.periph))
		begin
			sel_nxt.secondary = '0;
			sel_nxt.primary   = '0;
		end
		else if (|sel_nxt.secondary)
			sel_nxt.primary = '0;
		sel_nxt.ram       = sel_nxt.ram && ram_ok;
		sel_nxt.secondary = sel_nxt.secondary & {SEC_N{sec_ok}};
		sel_nxt.primary   = sel_nxt.primary & {PRI_N{pri_ok}};
	end

	assign cfg_hit = dterm[CFG_T];

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			sel_r <= '0;
		else
			sel_r <= sel_nxt;
	end

	// ---------------------------------------------------------------
	// Registers on the internal data bus
	// ---------------------------------------------------------------
	logic [7:0]       page_nxt;
	logic [7:0]       map_nxt;
	logic [OMC_N-1:0] omc_nxt;
	logic [7:0]       data_nxt;
	logic             oe_nxt;
	logic [7:0]       data_r;
	logic             oe_r;
	logic [ECS_N-1:0] ecs_r;
	logic             wr_cfg;
	logic             rd_cfg;

	assign wr_cfg = cfg_hit && ctrl_i.write;
	assign rd_cfg = cfg_hit && ctrl_i.read;

	always_comb
	begin
		page_nxt = page_r;
		map_nxt  = map_r;
		omc_nxt  = omc_d;
		data_nxt = 8'h00;
		oe_nxt   = rd_cfg;
		// Bus loads override the array terms for the same cycle
		if (wr_cfg)
		begin
			unique case (addr_i[7:0])
				OFF_PAGE:   page_nxt = data_i;
				OFF_MAP:    map_nxt = data_i & MAP_USED_MASK;
				OFF_OMC_AB: omc_nxt[7:0] = data_i;
				OFF_OMC_BC: omc_nxt[15:8] = data_i;
				default:    page_nxt = page_r;
			endcase
		end
		if (rd_cfg)
		begin
			unique case (addr_i[7:0])
				OFF_PAGE:   data_nxt = page_r;
				OFF_MAP:    data_nxt = map_r;
				OFF_OMC_AB: data_nxt = omc_r[7:0];
				OFF_OMC_BC: data_nxt = omc_r[15:8];
				OFF_IMC_A:  data_nxt = input_macrocell_i[7:0];
				OFF_IMC_B:  data_nxt = input_macrocell_i[15:8];
				OFF_IMC_C:  data_nxt = input_macrocell_i[23:16];
				default:    data_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			page_r <= PAGE_RESET;
			map_r  <= MAP_INIT;
			omc_r  <= '0;
			data_r <= 8'h00;
			oe_r   <= 1'b0;
			ecs_r  <= '0;
		end
		else
		begin
			page_r <= page_nxt;
			map_r  <= map_nxt;
			omc_r  <= omc_nxt;
			data_r <= data_nxt;
			oe_r   <= oe_nxt;
			ecs_r  <= ecs_d;
		end
	end

	// ---------------------------------------------------------------
	// Standby detection
	// ---------------------------------------------------------------
	// Only flags standby; the arrays themselves are modelled as
	// always awake, so the extra delay shows up off-chip only
	logic [BUS_W-1:0] prev_r;
	logic [3:0]       cnt_r;
	logic [3:0]       cnt_nxt;
	logic             stby_r;
	logic             stby_nxt;

	always_comb
	begin
		cnt_nxt = 4'h0;
		if (in_bus == prev_r)
			cnt_nxt = (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
		stby_nxt = !turbo_i && (cnt_nxt >= STBY_CYC);
	end

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			prev_r <= '0;
			cnt_r  <= 4'h0;
			stby_r <= 1'b0;
		end
		else
		begin
			prev_r <= in_bus;
			cnt_r  <= cnt_nxt;
			stby_r <= stby_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign sel_o                       = sel_r;
	assign page_bits_o                 = page_r;
	assign peripheral_io_mode_enable_o = map_r[MAP_PIO];
	assign external_chip_selects_o     = ecs_r;
	assign output_macrocell_o          = omc_r;
	assign data_o                      = data_r;
	assign data_oe_o                   = oe_r;
	assign standby_o                   = stby_r;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	page_write_a: assert property (
		wr_cfg && addr_i[7:0] == OFF_PAGE |=> page_bits_o == $past(data_i))
		else $error("page register did not load");
	page_read_a: assert property (
		rd_cfg && addr_i[7:0] == OFF_PAGE |=>
		data_oe_o && data_o == $past(page_bits_o))
		else $error("page register read back wrong");
	map_write_a: assert property (
		wr_cfg && addr_i[7:0] == OFF_MAP |=>
		peripheral_io_mode_enable_o == $past(data_i[MAP_PIO]))
		else $error("space map did not load");
	sec_wins_a: assert property (
		sel_o.secondary != '0 |-> sel_o.primary == '0)
		else $error("primary and secondary flash both selected");
	ram_wins_a: assert property (
		sel_o.ram || (|sel_o.periph) |->
		sel_o.primary == '0 && sel_o.secondary == '0)
		else $error("flash selected inside a higher space");
	periph_mode_a: assert property (
		sel_o.periph != '0 |-> $past(map_r[MAP_PIO]))
		else $error("peripheral select outside peripheral mode");
	pri_gate_a: assert property (
		sel_o.primary != '0 |->
		$past((ctrl_i.read && map_r[MAP_PRI_DATA]) ||
		(ctrl_i.fetch && map_r[MAP_PRI_CODE])))
		else $error("primary flash reached by a closed strobe");
	standby_on_a: assert property (
		($stable(in_bus) && !turbo_i)[*8] |=> standby_o)
		else $error("no standby after stable inputs");
	turbo_awake_a: assert property (
		turbo_i |=> !standby_o)
		else $error("standby while turbo is on");

	sec_over_c:   cover property (sel_o.secondary != '0);
	standby_c:    cover property (standby_o);
	page_rw_c:    cover property (wr_cfg ##1 rd_cfg ##1 data_oe_o);
	periph_sel_c: cover property (sel_o.periph != '0);

endmodule

// *** testbench/mmpd_mcu_model.sv ***
// Microcontroller bus model that drives the block's config and decode inputs
`timescale 1ns/1ps
module mmpd_mcu_model
	import mmpd_pkg::*;
(
	// Clock
	input  wire logic        mclk_i,
	// Bus towards the block
	output logic [19:0]      addr_o,
	output mmpd_ctrl_s       ctrl_o,
	output logic [7:0]       wdata_o,
	// Answer from the block
	input  wire logic [7:0]  rdata_i,
	input  wire logic        rdata_oe_i
);
	// Config space sits at b000h, inside the sector 0 flash window; config beats flash
	localparam logic [7:0] CFG_HI = 8'hb0;

	initial
	begin
		addr_o  = 20'h00000;
		ctrl_o  = '0;
		wdata_o = 8'h00;
	end

	// Request after a falling edge, held over exactly one rising edge
	task automatic drive(input logic [19:0] a, input mmpd_ctrl_s c,
		input logic [7:0] d);
	begin
		@(negedge mclk_i);
		addr_o  = a;
		ctrl_o  = c;
		wdata_o = d;
		@(negedge mclk_i);
	end
	endtask

	// Released data must not look like the last value written
	task automatic release_bus();
	begin
		ctrl_o  = '0;
		wdata_o = ~wdata_o;
	end
	endtask

	// The map may be rewritten at any time to move memories between spaces
	task automatic write_reg(input logic [7:0] off, input logic [7:0] d);
	begin
		drive({4'h0, CFG_HI, off}, mmpd_ctrl_s'(5'b00001), d);
		release_bus();
	end
	endtask

	task automatic read_reg(input logic [7:0] off, output logic [7:0] d,
		output logic o);
	begin
		drive({4'h0, CFG_HI, off}, mmpd_ctrl_s'(5'b00010), 8'h00);
		d = rdata_i;
		o = rdata_oe_i;
		release_bus();
	end
	endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the memory map and page decode block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench
	import mmpd_pkg::*;
;
	localparam int DW = DEC_TERMS * BUS_W;
	localparam int GW = GEN_TERMS * BUS_W;
	localparam logic [72:0] PG_CARE = 73'h00ff00000000f000;
	localparam logic [72:0] PG_VAL  = 73'h0001000000004000;

	typedef struct packed {
		logic [7:0]  map;
		logic [7:0]  page;
		logic [1:0]  fr;
		logic [19:0] addr;
		logic [7:0]  pri;
		logic [3:0]  sec;
		logic [2:0]  rcj;
	} mmpd_row_s;

	function automatic logic [DW-1:0] dterm(input int t, input logic [72:0] v);
		return DW'(v) << (t * BUS_W);
	endfunction

	// Sector 0 a000-bfff, sector 1 4000h on page 1, boot 8000-9fff,
	// boot 1 b800-bfff over sector 0, SRAM 8000-87ff, config b0xxh,
	// test port c000h qualified by read, peripheral 0 a8xxh
	localparam logic [DW-1:0] DCARE = dterm(0, 73'he000) | dterm(3, PG_CARE)
		| dterm(24, 73'he000) | dterm(36, 73'hf800) | dterm(38, 73'hff00)
		| dterm(39, 73'h2ffff) | dterm(27, 73'hf800) | dterm(40, 73'hff00);
	localparam logic [DW-1:0] DVAL = dterm(0, 73'ha000) | dterm(3, PG_VAL)
		| dterm(24, 73'h8000) | dterm(36, 73'h8000) | dterm(38, 73'hb000)
		| dterm(39, 73'h2c000) | dterm(27, 73'hb800) | dterm(40, 73'ha800);
	localparam logic [GW-1:0] GBIT = GW'(73'h0001000000000000);

	logic        mclk;
	logic        reset_n;
	logic        mode_20bit;
	logic        turbo;
	logic [4:0]  ctrl_block;
	logic [23:0] input_macrocell;
	logic [19:0] addr;
	mmpd_ctrl_s  ctrl;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        rdata_oe;
	mmpd_sel_s   sel;
	logic [7:0]  page_bits;
	logic        pio;
	logic [2:0]  ecs;
	logic [15:0] output_macrocell;
	logic        standby;
	logic [7:0]  rd;
	logic        oe;
	int          n;
	int          err_count = 0;
	int          num_checks = 0;

	mmpd_row_s rows [16] = '{
		'{8'h0c, 8'h00, 2'b10, 20'h0a800, 8'h01, 4'h0, 3'b000},
		'{8'h1c, 8'h00, 2'b01, 20'h0b800, 8'h00, 4'h2, 3'b000},
		'{8'h0c, 8'h00, 2'b01, 20'h08000, 8'h00, 4'h0, 3'b100},
		'{8'h0c, 8'h00, 2'b01, 20'h08800, 8'h00, 4'h1, 3'b000},
		'{8'h0c, 8'h00, 2'b01, 20'h0a000, 8'h00, 4'h0, 3'b000},
		'{8'h0c, 8'h00, 2'b10, 20'h0a000, 8'h01, 4'h0, 3'b000},
		'{8'h0c, 8'h00, 2'b10, 20'h08000, 8'h00, 4'h0, 3'b000},
		'{8'h14, 8'h00, 2'b01, 20'h0a000, 8'h01, 4'h0, 3'b000},
		'{8'h14, 8'h00, 2'b10, 20'h0a000, 8'h01, 4'h0, 3'b000},
		'{8'h01, 8'h00, 2'b10, 20'h08000, 8'h00, 4'h0, 3'b100},
		'{8'h02, 8'h00, 2'b10, 20'h08800, 8'h00, 4'h1, 3'b000},
		'{8'h00, 8'h00, 2'b01, 20'h08800, 8'h00, 4'h0, 3'b000},
		'{8'h10, 8'h01, 2'b01, 20'h04000, 8'h02, 4'h0, 3'b000},
		'{8'h10, 8'h00, 2'b01, 20'h04000, 8'h00, 4'h0, 3'b000},
		'{8'h1c, 8'h00, 2'b01, 20'h0b010, 8'h00, 4'h0, 3'b010},
		'{8'h0c, 8'h00, 2'b01, 20'h0c000, 8'h00, 4'h0, 3'b001}
	};

	mmpd_mcu_model mcu (.mclk_i(mclk), .addr_o(addr), .ctrl_o(ctrl),
		.wdata_o(wdata), .rdata_i(rdata), .rdata_oe_i(rdata_oe));

	mmpd_core #(.DEC_CARE(DCARE), .DEC_VAL(DVAL), .GEN_CARE(GBIT),
		.GEN_VAL(GBIT), .ECS_SEL((ECS_N * GEN_TERMS)'(1))) dut (
		.mclk_i(mclk), .reset_n_i(reset_n), .addr_i(addr), .ctrl_i(ctrl),
		.data_i(wdata), .data_o(rdata), .data_oe_o(rdata_oe),
		.mode_20bit_i(mode_20bit), .turbo_i(turbo),
		.ctrl_block_i(ctrl_block), .power_down_input_i(1'b0),
		.input_macrocell_i(input_macrocell), .port_d_i(3'h0), .sec_ready_i(1'b1),
		.sel_o(sel), .page_bits_o(page_bits),
		.peripheral_io_mode_enable_o(pio), .external_chip_selects_o(ecs),
		.output_macrocell_o(output_macrocell), .standby_o(standby));

	task automatic finish_test();
	begin
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial
	begin
		reset_n = 1'b0;
		mode_20bit = 1'b0;
		turbo = 1'b1;
		ctrl_block = 5'h00;
		input_macrocell = 24'h3c5a96;
		repeat (12) @(negedge mclk);
		reset_n = 1'b1;
		`CHK("page_rst", 8'h00, page_bits)
		`CHK("sel_rst", 17'h00000, sel)
		foreach (rows[i])
		begin
			mcu.write_reg(OFF_MAP, rows[i].map);
			mcu.write_reg(OFF_PAGE, rows[i].page);
			mcu.drive(rows[i].addr, mmpd_ctrl_s'({2'b00, rows[i].fr, 1'b0}), 8'h00);
			`CHK("sel", {rows[i].pri, rows[i].sec, rows[i].rcj, 2'b00}, sel)
			mcu.release_bus();
		end
		// Page register write, read back and one-cycle read answer
		mcu.write_reg(OFF_PAGE, 8'ha5);
		`CHK("page", 8'ha5, page_bits)
		mcu.read_reg(OFF_PAGE, rd, oe);
		`CHK("page_rd", 9'h1a5, {oe, rd})
		@(negedge mclk);
		`CHK("oe_drop", 1'b0, rdata_oe)
		mcu.write_reg(8'h55, 8'h33);
		`CHK("page_kept", 8'ha5, page_bits)
		mcu.read_reg(8'h55, rd, oe);
		`CHK("unmapped_rd", 9'h100, {oe, rd})
		// Unused map bits read as zero; bit 7 turns on peripheral mode
		mcu.write_reg(OFF_MAP, 8'hff);
		`CHK("pio", 1'b1, pio)
		mcu.read_reg(OFF_MAP, rd, oe);
		`CHK("map_rd", 8'h9f, rd)
		// Peripheral window over primary sector 0 wins in peripheral mode
		mcu.drive(20'h0a800, mmpd_ctrl_s'(5'b00010), 8'h00);
		`CHK("sel_periph", 17'h00001, sel)
		mcu.release_bus();
		mcu.write_reg(OFF_MAP, 8'h0c);
		mode_20bit = 1'b1;
		mcu.drive(20'ha0000, mmpd_ctrl_s'(5'b00100), 8'h00);
		`CHK("sel_20bit", 17'h00200, sel)
		mcu.release_bus();
		mode_20bit = 1'b0;
		ctrl_block = 5'b00010;
		mcu.drive(20'h0c000, mmpd_ctrl_s'(5'b00010), 8'h00);
		`CHK("jtag_blocked", 1'b0, sel.jtag)
		mcu.release_bus();
		ctrl_block = 5'h00;
		mcu.write_reg(OFF_PAGE, 8'h01);
		repeat (2) @(negedge mclk);
		`CHK("ecs_on", 3'b001, ecs)
		mcu.write_reg(OFF_PAGE, 8'h00);
		repeat (2) @(negedge mclk);
		`CHK("ecs_off", 3'b000, ecs)
		mcu.write_reg(OFF_OMC_BC, 8'h69);
		`CHK("omc_load", 8'h69, output_macrocell[15:8])
		mcu.read_reg(OFF_IMC_B, rd, oe);
		`CHK("imc_rd", 8'h5a, rd)
		// Standby only with turbo off and quiet inputs; bounded wait
		turbo = 1'b0;
		for (n = 0; n < 16 && standby !== 1'b1; n++)
			@(negedge mclk);
		if (n == 16)
		begin
			err_count++;
			finish_test();
		end
		`CHK("stby_delay", 1'b1, 1'(n >= 7 && n <= 10))
		mcu.drive(20'h01234, mmpd_ctrl_s'(5'b00000), 8'h00);
		`CHK("stby_wake", 1'b0, standby)
		turbo = 1'b1;
		repeat (12) @(negedge mclk);
		`CHK("turbo_on", 1'b0, standby)
		// Second reset in mid-run restores page and map
		mcu.write_reg(OFF_PAGE, 8'h5a);
		mcu.write_reg(OFF_MAP, 8'h94);
		reset_n = 1'b0;
		@(negedge mclk);
		reset_n = 1'b1;
		`CHK("page_rst2", 8'h00, page_bits)
		`CHK("pio_rst", 1'b0, pio)
		mcu.read_reg(OFF_MAP, rd, oe);
		`CHK("map_rst", MAP_RESET, rd)
		finish_test();
	end
endmodule
